// >>> rtl/isd_datapath.sv
// per-pin serialiser, deserialiser, delay and clock forwarding
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
module isd_datapath #(
    parameter int PIN_W = 1
) (
    // clock and resets
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ioRst,
    input wire logic delayRst,
    input wire logic ddrSyncRst,
    input wire logic clkEnable,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output isd_pkg::isd_apb_rsp_t apbRsp,
    // pins
    input wire logic [PIN_W-1:0] dataInPin,
    output logic [PIN_W-1:0] dataOutPin,
    output logic [PIN_W-1:0] dataOutEn,
    output logic fwdClkPin,
    // fabric receive
    output logic [PIN_W*isd_pkg::ISD_MAXF-1:0] rxWord,
    output logic rxValid,
    output logic [PIN_W-1:0] firstEdgeOutput,
    output logic [PIN_W-1:0] secondEdgeOutput,
    input wire logic [PIN_W-1:0] shiftReq,
    // fabric transmit
    input wire logic [PIN_W*isd_pkg::ISD_MAXF-1:0] txWord,
    input wire logic txDisable,
    output logic txTake,
    // per-pin delay control
    input wire logic [PIN_W-1:0] tapStep,
    input wire logic [PIN_W-1:0] tapUp,
    input wire logic [PIN_W-1:0] tapLoad,
    input wire logic [PIN_W*isd_pkg::ISD_TAP_W-1:0] tapLoadValue,
    output logic [PIN_W*isd_pkg::ISD_TAP_W-1:0] tapCurrentValue
);
    import isd_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [3:0] effFactor(isd_ctrl_t c);
        if (c.serEn)
            effFactor = c.factor;
        else if (c.ddr)
            effFactor = 4'h2;
        else
            effFactor = 4'h1;
    endfunction

    function automatic logic cfgOk(isd_ctrl_t c);
        if (!c.serEn)
            cfgOk = 1'b1;
        else if (!c.ddr)
            cfgOk = c.factor >= ISD_SDR_MIN && c.factor <= ISD_SDR_MAX;
        else
            cfgOk = c.factor == 4'h4 || c.factor == 4'h6 ||
                c.factor == 4'h8 || c.factor == 4'hA ||
                c.factor == 4'hE;
    endfunction

    function automatic logic [ISD_TAP_W-1:0] stepTap(
        logic [ISD_TAP_W-1:0] cur, logic up);
        if (up)
            stepTap = (cur == ISD_TAP_MAX) ? cur : cur + 5'h01;
        else
            stepTap = (cur == 5'h00) ? cur : cur - 5'h01;
    endfunction

    // keeps the last factor samples, boundary moved back by ofs
    function automatic logic [ISD_MAXF-1:0] window(
        logic [ISD_HIST-1:0] h, logic [3:0] f, logic [3:0] ofs);
        logic [ISD_HIST-1:0] s;
        logic [ISD_MAXF-1:0] w;
        s = h >> (ISD_HIST - int'(f) - int'(ofs));
        for (int i = 0; i < ISD_MAXF; i++)
            w[i] = (i < int'(f)) ? s[i] : 1'b0;
        window = w;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    isd_ctrl_t ctrl_ff;
    logic [ISD_TAP_W-1:0] cfgTap_ff;
    isd_apb_rsp_t apbRsp_ff;
    isd_state_t st_ff;
    logic phase_ff;
    logic [3:0] slot_ff;
    logic [15:0] frameCnt_ff;
    logic [ISD_TAP_W-1:0] tap_ff [PIN_W];
    logic [ISD_TAPS-1:0] inLine_ff [PIN_W];
    logic [ISD_TAPS-1:0] outLine_ff [PIN_W];
    logic [ISD_TAPS-1:0] oeLine_ff;
    logic [ISD_TAPS-1:0] fwdLine_ff;
    logic [ISD_HIST-1:0] hist_ff [PIN_W];
    logic [3:0] ofs_ff [PIN_W];
    logic [ISD_CELL-1:0] txMaster_ff [PIN_W];
    logic [ISD_SLAVE-1:0] txSlave_ff [PIN_W];
    logic [PIN_W-1:0] outBit_ff, lastA_ff, lastB_ff;
    logic oeBit_ff, fwdBit_ff;
    logic [PIN_W*ISD_MAXF-1:0] rxWord_ff;
    logic rxValid_ff, txTake_ff, fwdClkPin_ff;
    logic [PIN_W-1:0] dataOutPin_ff, dataOutEn_ff;
    logic [PIN_W-1:0] firstEdge_ff, secondEdge_ff;

    logic [3:0] fac;
    logic apbAcc, hit, run, rising, slotTick, frameStart, frameEnd;
    logic cascade, dlyOn, ctrlWr;
    logic [PIN_W-1:0] sample;
    logic [31:0] rdMux;

    assign fac = effFactor(ctrl_ff);
    assign cascade = ctrl_ff.serEn && ctrl_ff.factor > 4'h8;
    assign dlyOn = ctrl_ff.dly != DLY_NONE;
    assign run = st_ff == ST_RUN;
    assign rising = !phase_ff;
    // gate only the slot advance; flops themselves keep clocking
    assign slotTick = run && (!ctrl_ff.useClkEn || clkEnable) &&
        (ctrl_ff.ddr || rising);
    assign frameStart = slotTick && slot_ff == 4'h0;
    assign frameEnd = slotTick && slot_ff == fac - 4'h1;

    always_comb
    begin
        for (int p = 0; p < PIN_W; p++)
            sample[p] = dlyOn ? inLine_ff[p][tap_ff[p]] : dataInPin[p];
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign apbAcc = psel && penable;
    assign hit = paddr == ISD_OFS_CTRL || paddr == ISD_OFS_TAP ||
        paddr == ISD_OFS_STAT;
    assign ctrlWr = apbAcc && apbRsp_ff.pready && pwrite &&
        paddr == ISD_OFS_CTRL;

    always_comb
    begin
        rdMux = 32'h0000_0000;
        case (paddr)
            ISD_OFS_CTRL: rdMux[15:0] = ctrl_ff;
            ISD_OFS_TAP: rdMux[ISD_TAP_W-1:0] = cfgTap_ff;
            ISD_OFS_STAT:
            begin
                rdMux[ISD_ST_ERR] = !cfgOk(ctrl_ff);
                rdMux[ISD_ST_CASC] = cascade;
                rdMux[ISD_ST_RUN] = run;
                rdMux[ISD_ST_OFS +: 4] = ofs_ff[0];
                rdMux[ISD_ST_TAP +: ISD_TAP_W] = tap_ff[0];
                rdMux[ISD_ST_CNT +: 16] = frameCnt_ff;
            end
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            apbRsp_ff <= '0;
            ctrl_ff <= ISD_CTRL_RST;
            cfgTap_ff <= ISD_TAP_RST;
        end
        else
        begin
            apbRsp_ff.pready <= apbAcc && !apbRsp_ff.pready;
            if (apbAcc && !apbRsp_ff.pready)
            begin
                apbRsp_ff.prdata <= rdMux;
                apbRsp_ff.pslverr <= !hit;
            end
            if (ctrlWr)
                ctrl_ff <= pwdata[15:0];
            if (apbAcc && apbRsp_ff.pready && pwrite &&
                paddr == ISD_OFS_TAP)
                cfgTap_ff <= pwdata[ISD_TAP_W-1:0];
        end
    end

    // ----------------------------------------
    // framing
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= ST_IDLE;
            phase_ff <= 1'b0;
            slot_ff <= 4'h0;
            frameCnt_ff <= 16'h0000;
        end
        else if (ioRst)
        begin
            st_ff <= ST_IDLE;
            phase_ff <= 1'b0;
            slot_ff <= 4'h0;
            frameCnt_ff <= 16'h0000;
        end
        else
        begin
            case (st_ff)
                ST_IDLE:
                    if (cfgOk(ctrl_ff))
                        st_ff <= ST_RUN;
                ST_RUN:
                    // a new setup restarts framing from slot zero
                    if (!cfgOk(ctrl_ff) || ctrlWr)
                        st_ff <= ST_IDLE;
                default: st_ff <= ST_IDLE;
            endcase
            phase_ff <= run && !phase_ff;
            if (!run)
                slot_ff <= 4'h0;
            else if (frameEnd)
                slot_ff <= 4'h0;
            else if (slotTick)
                slot_ff <= slot_ff + 4'h1;
            if (frameEnd)
                frameCnt_ff <= frameCnt_ff + 16'h0001;
        end
    end

    // ----------------------------------------
    // delay taps
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int p = 0; p < PIN_W; p++)
            begin
                tap_ff[p] <= ISD_TAP_RST;
                inLine_ff[p] <= '0;
            end
        end
        else
        begin
            for (int p = 0; p < PIN_W; p++)
            begin
                inLine_ff[p] <= {inLine_ff[p][ISD_TAPS-2:0], dataInPin[p]};
                if (delayRst || ctrl_ff.dly == DLY_FIXED ||
                    ctrl_ff.dly == DLY_NONE)
                    tap_ff[p] <= cfgTap_ff;
                else if (ctrl_ff.dly == DLY_VARLOAD && tapLoad[p])
                    tap_ff[p] <= tapLoadValue[p*ISD_TAP_W +: ISD_TAP_W];
                else if (tapStep[p])
                    tap_ff[p] <= stepTap(tap_ff[p], tapUp[p]);
            end
        end
    end

    // ----------------------------------------
    // receive path
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxWord_ff <= '0;
            rxValid_ff <= 1'b0;
            for (int p = 0; p < PIN_W; p++)
            begin
                hist_ff[p] <= '0;
                ofs_ff[p] <= 4'h0;
            end
        end
        else if (ioRst || !run)
        begin
            rxWord_ff <= '0;
            rxValid_ff <= 1'b0;
            for (int p = 0; p < PIN_W; p++)
            begin
                hist_ff[p] <= '0;
                ofs_ff[p] <= 4'h0;
            end
        end
        else
        begin
            rxValid_ff <= frameEnd;
            for (int p = 0; p < PIN_W; p++)
            begin
                logic [ISD_HIST-1:0] nh;
                logic [ISD_MAXF-1:0] w;
                nh = {sample[p], hist_ff[p][ISD_HIST-1:1]};
                w = window(nh, fac, ofs_ff[p]);
                if (slotTick)
                    hist_ff[p] <= nh;
                // port present in every mode; idle low means no slip
                if (shiftReq[p])
                    ofs_ff[p] <= (ofs_ff[p] >= fac - 4'h1) ? 4'h0 :
                        ofs_ff[p] + 4'h1;
                if (frameEnd)
                    for (int s = 0; s < ISD_MAXF; s++)
                        rxWord_ff[s*PIN_W + p] <= w[s];
            end
        end
    end

    // dual-edge capture register alignment
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            firstEdge_ff <= '0;
            secondEdge_ff <= '0;
            lastA_ff <= '0;
            lastB_ff <= '0;
        end
        else if (ioRst || !run || (ctrl_ff.ddrRstSync && ddrSyncRst))
        begin
            firstEdge_ff <= '0;
            secondEdge_ff <= '0;
            lastA_ff <= '0;
            lastB_ff <= '0;
        end
        else if (slotTick && ctrl_ff.ddr && !ctrl_ff.serEn)
        begin
            if (rising)
            begin
                lastA_ff <= sample;
                case (ctrl_ff.inAlign)
                    ALN_OPP: firstEdge_ff <= sample;
                    ALN_SAME:
                    begin
                        firstEdge_ff <= sample;
                        secondEdge_ff <= lastB_ff;
                    end
                    ALN_PIPE:
                    begin
                        firstEdge_ff <= lastA_ff;
                        secondEdge_ff <= lastB_ff;
                    end
                    default: firstEdge_ff <= sample;
                endcase
            end
            else
            begin
                lastB_ff <= sample;
                if (ctrl_ff.inAlign == ALN_OPP)
                    secondEdge_ff <= sample;
            end
        end
    end

    // ----------------------------------------
    // transmit path
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            outBit_ff <= '0;
            oeBit_ff <= 1'b0;
            txTake_ff <= 1'b0;
            for (int p = 0; p < PIN_W; p++)
            begin
                txMaster_ff[p] <= '0;
                txSlave_ff[p] <= '0;
            end
        end
        else if (ioRst || !run)
        begin
            outBit_ff <= '0;
            oeBit_ff <= 1'b0;
            txTake_ff <= 1'b0;
        end
        else
        begin
            txTake_ff <= frameStart;
            if (frameStart)
                oeBit_ff <= !txDisable;
            for (int p = 0; p < PIN_W; p++)
            begin
                if (frameStart)
                begin
                    outBit_ff[p] <= txWord[p];
                    for (int k = 0; k < ISD_CELL; k++)
                        txMaster_ff[p][k] <= txWord[(k+1)*PIN_W + p];
                    for (int k = 0; k < ISD_SLAVE; k++)
                        txSlave_ff[p][k] <=
                            txWord[(k+ISD_CELL+1)*PIN_W + p];
                end
                else if (slotTick)
                begin
                    if (!ctrl_ff.serEn && ctrl_ff.outAlign == ALN_OPP)
                        outBit_ff[p] <= txWord[PIN_W + p];
                    else
                        outBit_ff[p] <= txMaster_ff[p][0];
                    txMaster_ff[p] <= {cascade && txSlave_ff[p][0],
                        txMaster_ff[p][ISD_CELL-1:1]};
                    txSlave_ff[p] <= {1'b0, txSlave_ff[p][ISD_SLAVE-1:1]};
                end
            end
        end
    end

    // pin side: each pin's tap delays its data and enable; the tap of pin 0 delays the forwarded clock
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oeLine_ff <= '0;
            fwdLine_ff <= '0;
            fwdBit_ff <= 1'b0;
            fwdClkPin_ff <= 1'b0;
            dataOutPin_ff <= '0;
            dataOutEn_ff <= '0;
            for (int p = 0; p < PIN_W; p++)
                outLine_ff[p] <= '0;
        end
        else if (ioRst)
        begin
            oeLine_ff <= '0;
            fwdLine_ff <= '0;
            fwdBit_ff <= 1'b0;
            fwdClkPin_ff <= 1'b0;
            dataOutPin_ff <= '0;
            dataOutEn_ff <= '0;
            for (int p = 0; p < PIN_W; p++)
                outLine_ff[p] <= '0;
        end
        else
        begin
            if (!ctrl_ff.fwdEn || !run)
                fwdBit_ff <= 1'b0;
            else if (ctrl_ff.fwdDiv)
                fwdBit_ff <= slot_ff < ((fac + 4'h1) >> 1);
            else
                fwdBit_ff <= rising;
            oeLine_ff <= {oeLine_ff[ISD_TAPS-2:0], oeBit_ff};
            fwdLine_ff <= {fwdLine_ff[ISD_TAPS-2:0], fwdBit_ff};
            fwdClkPin_ff <= dlyOn ? fwdLine_ff[tap_ff[0]] : fwdBit_ff;
            for (int p = 0; p < PIN_W; p++)
            begin
                outLine_ff[p] <= {outLine_ff[p][ISD_TAPS-2:0], outBit_ff[p]};
                // same tap as the input side of this pin
                dataOutPin_ff[p] <= dlyOn ? outLine_ff[p][tap_ff[p]] :
                    outBit_ff[p];
                dataOutEn_ff[p] <= dlyOn ? oeLine_ff[tap_ff[p]] :
                    oeBit_ff;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign apbRsp = apbRsp_ff;
    assign dataOutPin = dataOutPin_ff;
    assign dataOutEn = dataOutEn_ff;
    assign fwdClkPin = fwdClkPin_ff;
    assign rxWord = rxWord_ff;
    assign rxValid = rxValid_ff;
    assign firstEdgeOutput = firstEdge_ff;
    assign secondEdgeOutput = secondEdge_ff;
    assign txTake = txTake_ff;

    always_comb
    begin
        for (int p = 0; p < PIN_W; p++)
            tapCurrentValue[p*ISD_TAP_W +: ISD_TAP_W] = tap_ff[p];
    end

endmodule

// >>> rtl/isd_pkg.sv
// constants, types and layouts of the per-pin serdes datapath
package isd_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int ISD_MAXF = 14;
    localparam int ISD_CELL = 8;
    localparam int ISD_SLAVE = ISD_MAXF - ISD_CELL - 1;
    localparam int ISD_HIST = 2 * ISD_MAXF;
    localparam int ISD_TAPS = 32;
    localparam int ISD_TAP_W = 5;
    localparam logic [ISD_TAP_W-1:0] ISD_TAP_MAX = 5'h1F;
    localparam logic [3:0] ISD_SDR_MIN = 4'h2;
    localparam logic [3:0] ISD_SDR_MAX = 4'h8;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ISD_OFS_CTRL = 8'h00;
    localparam logic [7:0] ISD_OFS_TAP = 8'h04;
    localparam logic [7:0] ISD_OFS_STAT = 8'h08;
    localparam logic [15:0] ISD_CTRL_RST = 16'h0190;
    localparam logic [ISD_TAP_W-1:0] ISD_TAP_RST = 5'h00;
    localparam int ISD_ST_ERR = 0;
    localparam int ISD_ST_CASC = 1;
    localparam int ISD_ST_RUN = 2;
    localparam int ISD_ST_OFS = 4;
    localparam int ISD_ST_TAP = 8;
    localparam int ISD_ST_CNT = 16;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {ALN_OPP, ALN_SAME, ALN_PIPE} isd_align_t;
    typedef enum logic [1:0] {
        DLY_NONE, DLY_FIXED, DLY_VAR, DLY_VARLOAD
    } isd_dly_t;
    typedef enum logic {ST_IDLE, ST_RUN} isd_state_t;

    typedef struct packed {
        logic ddrRstSync;
        logic useClkEn;
        isd_dly_t dly;
        logic fwdDiv;
        logic fwdEn;
        isd_align_t outAlign;
        isd_align_t inAlign;
        logic [3:0] factor;
        logic ddr;
        logic serEn;
    } isd_ctrl_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } isd_apb_rsp_t;

endpackage

// >>> testbench/isd_datapath_sva.sv
// port checker of the per-pin serdes datapath
`timescale 1ns/1ps
module isd_datapath_sva
    import isd_pkg::*;
#(
    parameter int PIN_W = 1
) (
    // clock and resets
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ioRst,
    input wire logic delayRst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire isd_pkg::isd_apb_rsp_t apbRsp,
    // pins and fabric
    input wire logic [PIN_W-1:0] dataOutPin,
    input wire logic [PIN_W*isd_pkg::ISD_MAXF-1:0] rxWord,
    input wire logic rxValid,
    input wire logic txTake,
    // delay control
    input wire logic [PIN_W-1:0] tapStep,
    input wire logic [PIN_W-1:0] tapUp,
    input wire logic [PIN_W-1:0] tapLoad,
    input wire logic [PIN_W*isd_pkg::ISD_TAP_W-1:0] tapLoadValue,
    input wire logic [PIN_W*isd_pkg::ISD_TAP_W-1:0] tapCurrentValue
);
    // ----------------------------------------
    // register mirror, kept from completed writes
    // ----------------------------------------
    isd_ctrl_t ctrl_ff;
    logic [4:0] tapReg_ff;
    logic ctrlWr;
    logic dlyVar;
    logic [4:0] tap0;
    int fw;
    assign ctrlWr = psel && penable && apbRsp.pready && pwrite
        && paddr == ISD_OFS_CTRL;
    assign dlyVar = ctrl_ff.dly[1];
    assign tap0 = tapCurrentValue[4:0];
    assign fw = !ctrl_ff.serEn ? (ctrl_ff.ddr ? 2 : 1) : int'(ctrl_ff.factor);
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            ctrl_ff <= isd_ctrl_t'(ISD_CTRL_RST);
        else if (ctrlWr)
            ctrl_ff <= isd_ctrl_t'(pwdata[15:0]);
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            tapReg_ff <= ISD_TAP_RST;
        else if (psel && penable && apbRsp.pready && pwrite
            && paddr == ISD_OFS_TAP)
            tapReg_ff <= pwdata[4:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_ready_late: assert property (psel && penable && !apbRsp.pready
        |=> apbRsp.pready) else $error("apb answer late");
    a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("apb ready longer than one cycle");
    a_err_unmapped: assert property (psel && penable && !apbRsp.pready
        && paddr > 8'h08 |=> apbRsp.pslverr) else $error("no error");
    a_word_width: assert property (
        rxValid && !$past(ctrlWr) && !$past(ctrlWr, 2)
        |-> (rxWord >> fw) == '0) else $error("bits beyond frame");
    a_io_clear: assert property (ioRst |=> rxWord == '0 && !rxValid
        && dataOutPin == '0 && !txTake) else $error("reset not idle");
    a_tap_up: assert property (dlyVar && tapStep[0] && tapUp[0]
        && !tapLoad[0] && !delayRst && tap0 != 5'h1F
        |=> tap0 == $past(tap0) + 5'h01) else $error("tap up wrong");
    a_tap_down: assert property (dlyVar && tapStep[0] && !tapUp[0]
        && !tapLoad[0] && !delayRst && tap0 != 5'h00
        |=> tap0 == $past(tap0) - 5'h01) else $error("tap down wrong");
    a_tap_load: assert property (ctrl_ff.dly == DLY_VARLOAD
        && tapLoad[0] && !delayRst
        |=> tap0 == $past(tapLoadValue[4:0])) else $error("tap load");
    a_tap_reset: assert property (delayRst
        |=> tap0 == $past(tapReg_ff)) else $error("tap reset value");
    a_take_pulse: assert property (txTake |=> !txTake)
        else $error("take longer than one cycle");
endmodule

bind isd_datapath isd_datapath_sva #(.PIN_W(PIN_W)) uSva (
    .clk_sys, .rst_b, .ioRst, .delayRst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .apbRsp, .dataOutPin, .rxWord, .rxValid, .txTake,
    .tapStep, .tapUp, .tapLoad, .tapLoadValue, .tapCurrentValue
);

// >>> testbench/isd_link_partner.sv
// far-side lane partner: loops the lane back or idles with toggling
`timescale 1ns/1ps
module isd_link_partner (
    // clock and mode
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic loopEn,
    // pins
    input wire logic dataOutPin,
    input wire logic dataOutEn,
    output logic dataInPin
);
    // released lane toggles so a stale level never passes as data
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            dataInPin <= 1'b0;
        else if (loopEn && dataOutEn)
            dataInPin <= dataOutPin;
        else
            dataInPin <= !dataInPin;
endmodule

// >>> testbench/test_isd_datapath.sv
// self-checking bench of the per-pin serdes datapath
`timescale 1ns/1ps
module test_isd_datapath;
    import isd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic ioRst = 1'b1;
    logic delayRst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic shiftReq = 1'b0, txDisable = 1'b0, loopEn = 1'b1;
    logic tapStep = 1'b0, tapUp = 1'b0, tapLoad = 1'b0;
    logic [4:0] tapLoadValue = 5'h00;
    logic [13:0] txWord = 14'h0000;
    isd_apb_rsp_t apbRsp;
    logic dataInPin, dataOutPin, dataOutEn, fwdClkPin, rxValid, txTake;
    logic [13:0] rxWord;
    logic [4:0] tapCurrentValue;
    logic [31:0] rd;
    logic err, firstEdge, secondEdge;
    int error_cnt = 0, tests_run = 0, seed = 55176, f, w, k;
    int cfgs[6] = '{2, 5, 8, 20, 26, 30};
    always #4 clk_sys = ~clk_sys;

    // sync reset of the dual-edge capture unused: async default holds
    isd_datapath #(.PIN_W(1)) DUT (
        .clk_sys, .rst_b, .ioRst, .delayRst, .ddrSyncRst(1'b0),
        .clkEnable(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .apbRsp, .dataInPin, .dataOutPin, .dataOutEn, .fwdClkPin, .rxWord,
        .rxValid, .firstEdgeOutput(firstEdge), .shiftReq,
        .secondEdgeOutput(secondEdge), .txWord, .txDisable, .txTake,
        .tapStep, .tapUp, .tapLoad, .tapLoadValue, .tapCurrentValue
    );
    isd_link_partner uPartner (
        .clk_sys, .rst_b, .loopEn, .dataOutPin, .dataOutEn, .dataInPin
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // a missing frame counts as a mismatch instead of hanging
    task automatic waitv(input int n);
        int c;
        c = 0;
        while (n > 0 && c < 400)
        begin
            @(posedge clk_sys);
            c++;
            if (rxValid === 1'b1)
                n--;
        end
        if (n > 0)
            chk(32'h0, 32'h1);
    endtask
    function automatic bit isrot(logic [13:0] got, int v, int fw);
        for (int r = 0; r < fw; r++)
            if (got === 14'(((v << r) | (v >> (fw - r))) & ((1 << fw) - 1)))
                return 1'b1;
        return 1'b0;
    endfunction
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (16) @(posedge clk_sys);
        ioRst <= 1'b0;
        @(posedge clk_sys);
        apb(1'b0, ISD_OFS_CTRL, 32'h0);
        chk(rd, 32'(ISD_CTRL_RST));
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        $display("registers done");
        for (int d = 0; d < 2; d++)
            for (f = 1; f < 16; f++)
            begin
                apb(1'b1, ISD_OFS_CTRL, 32'(f * 4 + d * 2 + 1));
                apb(1'b0, ISD_OFS_STAT, 32'h0);
                k = d ? (f inside {4, 6, 8, 10, 14}) : (f >= 2 && f <= 8);
                chk(32'(rd[0]), 32'(!k));
                chk(32'(rd[1]), 32'(f > 8));
            end
        $display("factor table done");
        // constant word looped back must arrive as a rotation of itself
        foreach (cfgs[i])
        begin
            f = cfgs[i] % 16;
            w = $random(seed) & ((1 << f) - 1);
            txWord <= 14'(w);
            apb(1'b1, ISD_OFS_CTRL, 32'(f * 4 + (cfgs[i] / 16) * 2 + 1));
            waitv(3);
            chk(32'(isrot(rxWord, w, f)), 32'h1);
            k = rxWord;
            shiftReq <= 1'b1;
            @(posedge clk_sys);
            shiftReq <= 1'b0;
            waitv(3);
            chk(32'(rxWord), 32'(((k << 1) | (k >> (f - 1))) & ((1 << f) - 1)));
        end
        txDisable <= 1'b1;
        waitv(2);
        chk(32'(dataOutEn), 32'h0);
        txDisable <= 1'b0;
        ioRst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(32'({rxWord, dataOutPin}), 32'h0);
        ioRst <= 1'b0;
        txWord <= 14'h0001;
        apb(1'b1, ISD_OFS_CTRL, 32'h0082);
        waitv(6);
        chk(32'(isrot(14'({firstEdge, secondEdge}), 1, 2)), 32'h1);
        $display("loopback done");
        for (int d = 0; d < 2; d++)
        begin
            apb(1'b1, ISD_OFS_CTRL, 32'h411 | 32'(d << 11));
            waitv(1);
            k = 0;
            w = 1;
            repeat (64)
            begin
                @(posedge clk_sys);
                if (fwdClkPin === 1'b1 && w == 0)
                    k++;
                w = fwdClkPin;
            end
            f = d ? 8 : 32;
            chk(32'(k >= f - 1 && k <= f), 32'h1);
        end
        $display("forwarding done");
        apb(1'b1, ISD_OFS_TAP, 32'h0B);
        apb(1'b1, ISD_OFS_CTRL, 32'h3011);
        tapLoadValue <= 5'($random(seed));
        tapLoad <= 1'b1;
        @(posedge clk_sys);
        k = tapLoadValue;
        tapLoad <= 1'b0;
        repeat (40)
        begin
            tapStep <= 1'($random(seed));
            tapUp <= 1'($random(seed));
            @(posedge clk_sys);
            if (tapStep)
                k = tapUp ? (k < 31 ? k + 1 : 31) : (k > 0 ? k - 1 : 0);
        end
        tapStep <= 1'b0;
        @(posedge clk_sys);
        chk(32'(tapCurrentValue), 32'(k));
        delayRst <= 1'b1;
        @(posedge clk_sys);
        delayRst <= 1'b0;
        @(posedge clk_sys);
        chk(32'(tapCurrentValue), 32'h0B);
        $display("taps done");
        final_report();
    end

    initial
    begin
        #400000;
        error_cnt++;
        final_report();
    end
endmodule
